// >>> hw/fld_regs.vh
`ifndef FLD_REGS_VH
`define FLD_REGS_VH
// ****************************************
// Timing and level constants.
// ****************************************
`define FLD_CLK_HZ          25000000
`define FLD_OFF_TIME_US     1500
`define FLD_OFF_CYCLES      ((`FLD_OFF_TIME_US * 25) )
`define FLD_GAIN_DELAY_US   400
`define FLD_GAIN_CYCLES     ((`FLD_GAIN_DELAY_US * 25) )
`define FLD_US_DIV          25
`define FLD_IDX_W           6
`define FLD_IDX_OFF         6'h00
`define FLD_IDX_FULL        6'h01
`define FLD_IDX_ZERO        6'h20
`define FLD_LVL_W           8
`endif

// >>> hw/fld_level_rom.v
`include "fld_regs.vh"
module fld_level_rom (
	input  wire                  i_clk,
	input  wire [`FLD_IDX_W-1:0] i_idx,
	output reg  [`FLD_LVL_W-1:0] o_level
);
	// ****************************************
	// Current level in half-mA units, registered.
	// ****************************************
	always @(posedge i_clk) begin
		case (i_idx)
		6'h01: o_level <= 8'h2c;
		6'h02: o_level <= 8'h22;
		6'h03: o_level <= 8'h18;
		6'h04: o_level <= 8'h0f;
		6'h05: o_level <= 8'h06;
		6'h06: o_level <= 8'hfc;
		6'h07: o_level <= 8'hf2;
		6'h08: o_level <= 8'he8;
		6'h09: o_level <= 8'hde;
		6'h0a: o_level <= 8'hd5;
		6'h0b: o_level <= 8'hcb;
		6'h0c: o_level <= 8'hc2;
		6'h0d: o_level <= 8'hb8;
		6'h0e: o_level <= 8'hae;
		6'h0f: o_level <= 8'ha4;
		6'h10: o_level <= 8'h9b;
		6'h11: o_level <= 8'h91;
		6'h12: o_level <= 8'h88;
		6'h13: o_level <= 8'h7e;
		6'h14: o_level <= 8'h74;
		6'h15: o_level <= 8'h6a;
		6'h16: o_level <= 8'h61;
		6'h17: o_level <= 8'h57;
		6'h18: o_level <= 8'h4e;
		6'h19: o_level <= 8'h44;
		6'h1a: o_level <= 8'h3a;
		6'h1b: o_level <= 8'h30;
		6'h1c: o_level <= 8'h26;
		6'h1d: o_level <= 8'h1d;
		6'h1e: o_level <= 8'h14;
		6'h1f: o_level <= 8'h0a;
		default: o_level <= 8'h00;
		endcase
	end
endmodule

// >>> hw/fld_core.v
// How it works
// - First high from shutdown enables at zero current.
// - First falling edge sets full scale.
// - Each further falling edge up to the thirty-second steps current down, except the sixth (8'h06 to 8'hfc).
// - Thirty-second pulse gives zero current.
// - Pulse at zero returns to full scale.
// - Long low time enters shutdown.
// - Shutdown turns both sinks off.
// - Undervoltage disables all channels.
// - Pump starts at unity gain and stays there until regulation is lost.
// - Lost regulation selects 1.5x after delay.
// - Gain sequence restarts on every enable.
// - Pulse rates in supported range accepted.
// - One input controls both channels together.
// - Pulse counts map to tabulated levels.
// - Over-temperature shuts down until cooled.
`include "fld_regs.vh"
module fld_core #(
	parameter OFF_CYCLES  = `FLD_OFF_CYCLES,
	parameter GAIN_CYCLES = `FLD_GAIN_CYCLES
) (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_enable_dimming_input,
	input  wire       i_undervoltage,
	input  wire       i_over_temp,
	input  wire       i_temp_cooled,
	input  wire       i_regulation_ok,
	output reg        o_enabled,
	output wire [7:0] o_led_sink_first,
	output wire [7:0] o_led_sink_second,
	output wire       o_led_sink_first_oe,
	output wire       o_led_sink_second_oe,
	output reg        o_pump_gain_high,
	output reg        o_thermal_shutdown
);
	// ****************************************
	// Input synchronisers and edge detection.
	// ****************************************
	reg        sync1_reg;
	reg        sync2_reg;
	reg        in_prev_reg;
	reg  [1:0] aux1_reg;
	reg  [1:0] aux2_reg;
	wire       fall = in_prev_reg & ~sync2_reg;
	always @(posedge i_clk) begin
		if (i_rst) begin
			sync1_reg   <= 1'b0;
			sync2_reg   <= 1'b0;
			in_prev_reg <= 1'b0;
			aux1_reg    <= 2'h0;
			aux2_reg    <= 2'h0;
		end else begin
			sync1_reg   <= i_enable_dimming_input;
			sync2_reg   <= sync1_reg;
			in_prev_reg <= sync2_reg;
			aux1_reg    <= {i_over_temp, i_temp_cooled};
			aux2_reg    <= aux1_reg;
		end
	end
	reg        uv1_reg;
	reg        uv2_reg;
	reg        reg1_reg;
	reg        reg2_reg;
	always @(posedge i_clk) begin
		if (i_rst) begin
			uv1_reg  <= 1'b1;
			uv2_reg  <= 1'b1;
			reg1_reg <= 1'b1;
			reg2_reg <= 1'b1;
		end else begin
			uv1_reg  <= i_undervoltage;
			uv2_reg  <= uv1_reg;
			reg1_reg <= i_regulation_ok;
			reg2_reg <= reg1_reg;
		end
	end
	// ****************************************
	// Microsecond timebase.
	// ****************************************
	reg  [4:0] div_reg;
	wire       us_tick = (div_reg == 5'd24);
	always @(posedge i_clk) begin
		if (i_rst || us_tick)
			div_reg <= 5'h00;
		else
			div_reg <= div_reg + 5'h01;
	end
	// ****************************************
	// Shutdown low-time counter and enable.
	// ****************************************
	reg  [15:0] low_cnt_reg;
	reg         en_d_reg;
	wire        off_hit = (low_cnt_reg >= OFF_CYCLES[15:0]);
	wire        start = o_enabled & ~en_d_reg;
	always @(posedge i_clk) begin
		if (i_rst) begin
			low_cnt_reg <= 16'h0000;
			o_enabled   <= 1'b0;
			en_d_reg    <= 1'b0;
		end else begin
			en_d_reg <= o_enabled;
			if (sync2_reg)
				low_cnt_reg <= 16'h0000;
			else if (!off_hit)
				low_cnt_reg <= low_cnt_reg + 16'h0001;
			if (sync2_reg)
				o_enabled <= 1'b1;
			else if (off_hit)
				o_enabled <= 1'b0;
		end
	end
	// ****************************************
	// Step index.
	// ****************************************
	reg  [`FLD_IDX_W-1:0] idx_reg;
	always @(posedge i_clk) begin
		if (i_rst || !o_enabled)
			idx_reg <= `FLD_IDX_OFF;
		else if (fall) begin
			if (idx_reg == `FLD_IDX_OFF || idx_reg == `FLD_IDX_ZERO)
				idx_reg <= `FLD_IDX_FULL;
			else
				idx_reg <= idx_reg + 6'h01;
		end
	end
	wire [7:0] level;
	fld_level_rom u_rom (
		.i_clk   (i_clk),
		.i_idx   (idx_reg),
		.o_level (level)
	);
	// ****************************************
	// Thermal shutdown with hysteresis.
	// ****************************************
	always @(posedge i_clk) begin
		if (i_rst)
			o_thermal_shutdown <= 1'b0;
		else if (aux2_reg[1])
			o_thermal_shutdown <= 1'b1;
		else if (aux2_reg[0])
			o_thermal_shutdown <= 1'b0;
	end
	wire drive = o_enabled & ~uv2_reg & ~o_thermal_shutdown;
	assign o_led_sink_first     = drive ? level : 8'h00;
	assign o_led_sink_second    = drive ? level : 8'h00;
	assign o_led_sink_first_oe  = drive;
	assign o_led_sink_second_oe = drive;
	// ****************************************
	// Charge-pump gain sequencing.
	// ****************************************
	reg  [13:0] gain_cnt_reg;
	wire        gain_hit = (gain_cnt_reg >= GAIN_CYCLES[13:0]);
	always @(posedge i_clk) begin
		if (i_rst || start || !o_enabled) begin
			gain_cnt_reg     <= 14'h0000;
			o_pump_gain_high <= 1'b0;
		end else if (!o_pump_gain_high) begin
			if (reg2_reg)
				gain_cnt_reg <= 14'h0000;
			else if (gain_hit)
				o_pump_gain_high <= 1'b1;
			else
				gain_cnt_reg <= gain_cnt_reg + 14'h0001;
		end
	end
endmodule

// >>> test/fld_core_props.sv
module fld_core_props #(
	parameter OFF_CYCLES  = 200,
	parameter GAIN_CYCLES = 50
) (
	input wire logic       i_clk, i_rst, i_enable_dimming_input,
	input wire logic       i_undervoltage, i_over_temp, i_temp_cooled,
	input wire logic       i_regulation_ok, o_enabled,
	input wire logic [7:0] o_led_sink_first, o_led_sink_second,
	input wire logic       o_led_sink_first_oe, o_led_sink_second_oe,
	input wire logic       o_pump_gain_high, o_thermal_shutdown
);
	timeunit 1ns;
	timeprecision 1ns;
	int low_cnt = 0;
	int bad_cnt = 0;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	always @(posedge i_clk) begin
		low_cnt <= i_enable_dimming_input ? 0 : low_cnt + 1;
		bad_cnt <= (i_regulation_ok || !o_enabled) ? 0 : bad_cnt + 1;
	end
	chk_sinks_match: assert property (o_led_sink_first == o_led_sink_second &&
		o_led_sink_first_oe == o_led_sink_second_oe) else $error("sinks differ");
	chk_off_hiz: assert property (!o_enabled [*2] |-> !o_led_sink_first_oe &&
		!o_led_sink_second_oe) else $error("sink driven in shutdown");
	chk_enable_zero: assert property ($rose(o_enabled) |->
		o_led_sink_first == 8'h00) else $error("current at enable");
	chk_gain_start: assert property ($rose(o_enabled) |->
		!o_pump_gain_high) else $error("gain high at enable");
	chk_gain_early: assert property ($rose(o_pump_gain_high) |->
		bad_cnt >= GAIN_CYCLES - 3) else $error("gain switched early");
	chk_gain_late: assert property (o_enabled && bad_cnt == GAIN_CYCLES + 6
		|-> o_pump_gain_high) else $error("gain switched late");
	chk_off_early: assert property ($fell(o_enabled) |->
		low_cnt >= OFF_CYCLES) else $error("shutdown early");
	chk_off_late: assert property (low_cnt == OFF_CYCLES + 6 |->
		!o_enabled) else $error("shutdown late");
	chk_uv_dark: assert property (i_undervoltage [*5] |->
		o_led_sink_first == 8'h00) else $error("current in undervoltage");
	chk_hot_set: assert property (i_over_temp [*5] |->
		o_thermal_shutdown) else $error("thermal shutdown missing");
	cover property ($fell(o_enabled));
	cover property ($rose(o_pump_gain_high));
	cover property ($rose(o_thermal_shutdown));
endmodule
bind fld_core fld_core_props #(.OFF_CYCLES(OFF_CYCLES),
	.GAIN_CYCLES(GAIN_CYCLES)) u_props (.*);

// >>> test/fld_host.sv
module fld_host (
	input  wire logic i_clk,
	output logic      o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_pin = 1'b0;
	task up;
		o_pin <= 1'b1;
	endtask
	task settle;
		repeat (260) @(posedge i_clk);
	endtask
	task pulse(input int lo, input int hi);
		o_pin <= 1'b0;
		repeat (lo) @(posedge i_clk);
		o_pin <= 1'b1;
		repeat (hi) @(posedge i_clk);
	endtask
	task drop(input int n);
		o_pin <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask
endmodule

// >>> test/fld_core_bench.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module fld_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rst = 1, uv = 0, ot = 0, tc = 0, rok = 1;
	logic       en, gh, ts, oe1, oe2;
	logic [7:0] s1, s2;
	wire        pin;
	int         failures = 0, comparisons = 0;
	always #20 clk = ~clk;
	fld_host u_host (.i_clk(clk), .o_pin(pin));
	fld_core #(.OFF_CYCLES(200), .GAIN_CYCLES(50)) i_dut (.i_clk(clk),
		.i_rst(rst), .i_enable_dimming_input(pin), .i_undervoltage(uv),
		.i_over_temp(ot), .i_temp_cooled(tc), .i_regulation_ok(rok),
		.o_enabled(en), .o_led_sink_first(s1), .o_led_sink_second(s2),
		.o_led_sink_first_oe(oe1), .o_led_sink_second_oe(oe2),
		.o_pump_gain_high(gh), .o_thermal_shutdown(ts));
	task give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wen(input logic v);
		for (int k = 0; k < 40 && en !== v; k++) @(posedge clk);
		if (en !== v) begin
			failures++;
			give_verdict;
		end
	endtask
	task t_steps;
		u_host.up;
		wen(1);
		u_host.settle;
		`CHK({s1, s2}, 16'h0000)
		u_host.pulse(8, 8);
		`CHK({s1, s2}, 16'h2c2c)
		u_host.pulse(150, 40);
		`CHK({s1, s2}, 16'h2222)
		for (int n = 3; n < 32; n++) u_host.pulse(8, 8);
		`CHK({s1, s2}, 16'h0a0a)
		u_host.pulse(8, 8);
		`CHK({s1, s2}, 16'h0000)
		u_host.pulse(8, 8);
		`CHK({s1, s2}, 16'h2c2c)
		$display("steps done");
	endtask
	task t_gain;
		`CHK(gh, 1'b0)
		rok <= 1'b0;
		repeat (40) @(posedge clk);
		`CHK(gh, 1'b0)
		repeat (20) @(posedge clk);
		`CHK(gh, 1'b1)
		u_host.drop(200);
		wen(0);
		`CHK({oe1, oe2}, 2'b00)
		u_host.up;
		wen(1);
		`CHK(gh, 1'b0)
		rok <= 1'b1;
		u_host.settle;
		$display("gain done");
	endtask
	task t_prot;
		u_host.pulse(8, 8);
		uv <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK({s1, s2}, 16'h0000)
		uv <= 1'b0;
		ot <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK({ts, s1}, 9'h100)
		ot <= 1'b0;
		tc <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK(ts, 1'b0)
		tc <= 1'b0;
		$display("protection done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_steps;
		t_gain;
		t_prot;
		give_verdict;
	end
endmodule
